// ===== core/scp_pkg.sv
// Package for the serial control port: word layout, mode codes and carriers
`default_nettype none
package scp_pkg;
  // ----------------------------------------
  // Word layout
  // ----------------------------------------
  localparam int WORD_W = 16;
  localparam int CNT_W = 4;
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 3;
  localparam int CFG_SEL_LSB = 3;
  localparam int CFG_SEL_W = 2;
  localparam int CFG_LSB = 5;
  localparam int CFG_W = 9;
  localparam int MEAS_BIT = 14;
  localparam int WD_LP_BIT = 15;
  localparam int CFG_BANKS = 4;

  // ----------------------------------------
  // Mode codes and reset values
  // ----------------------------------------
  localparam logic [2:0] MODE_ACT_SLEEP = 3'h2;
  localparam logic [2:0] MODE_ACT_ON = 3'h3;
  localparam logic [2:0] MODE_SLEEP = 3'h4;
  localparam logic [2:0] MODE_RX_ONLY = 3'h6;
  localparam logic [2:0] MODE_STOP = 3'h7;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [8:0] CFG_RST = 9'h000;

  typedef enum logic [2:0] {
    SCP_STANDBY,
    SCP_ACT_ON,
    SCP_ACT_SLEEP,
    SCP_SLEEP,
    SCP_RX_ONLY,
    SCP_STOP
  } scp_mode_t;

  typedef struct packed {
    logic transceiver_on;
    logic transceiver_rx_only;
    logic regulator_off;
    logic meas_on;
    logic watchdog_run;
    logic active;
  } scp_ctrl_t;

  typedef struct packed {
    logic [8:0] general;
    logic [8:0] switches;
    logic [8:0] cyclic_wake;
    logic [8:0] watchdog;
  } scp_cfg_t;
endpackage : scp_pkg
`default_nettype wire

// ===== core/scp_serial_port.sv
// Serial control port: link shifters, frame check, mode and configuration decode
`default_nettype none
module scp_serial_port (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic serial_clk,
  input wire logic select_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  input wire logic [15:0] diag_word,
  input wire logic wake_event,
  input wire logic load_above_threshold,
  output scp_pkg::scp_mode_t mode,
  output scp_pkg::scp_ctrl_t ctrl,
  output scp_pkg::scp_cfg_t cfg,
  output logic [15:0] control_word,
  output logic count_error
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_s1_r;
  logic rst_n_r;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // ----------------------------------------
  // Link side, serial clock domain
  // ----------------------------------------
  // Held in reset between frames by the core domain
  logic link_rst_r;
  logic [15:0] in_shift_r;
  logic [scp_pkg::CNT_W-1:0] fall_cnt_r;
  logic fall_seen_r;
  logic [scp_pkg::CNT_W-1:0] out_idx_r;
  logic rise_seen_r;

  always_ff @(negedge serial_clk or posedge link_rst_r) begin
    if (link_rst_r) begin
      in_shift_r <= scp_pkg::WORD_RST;
      fall_cnt_r <= '0;
      fall_seen_r <= 1'b0;
    end else begin
      in_shift_r <= {serial_in, in_shift_r[15:1]};
      fall_cnt_r <= fall_cnt_r + 4'h1;
      fall_seen_r <= 1'b1;
    end
  end

  always_ff @(posedge serial_clk or posedge link_rst_r) begin
    if (link_rst_r) begin
      out_idx_r <= '0;
      rise_seen_r <= 1'b0;
    end else begin
      out_idx_r <= out_idx_r + 4'h1;
      rise_seen_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // Select and wake synchronisers
  // ----------------------------------------
  logic sel_s1_r;
  logic sel_s2_r;
  logic sel_d_r;
  logic wake_s1_r;
  logic wake_s2_r;
  // Wake and load levels arrive from other domains
  logic load_s1_r;
  logic load_s2_r;

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sel_s1_r <= 1'b1;
      sel_s2_r <= 1'b1;
      sel_d_r <= 1'b1;
      wake_s1_r <= 1'b0;
      wake_s2_r <= 1'b0;
      load_s1_r <= 1'b0;
      load_s2_r <= 1'b0;
    end else begin
      sel_s1_r <= select_n;
      sel_s2_r <= sel_s1_r;
      sel_d_r <= sel_s2_r;
      wake_s1_r <= wake_event;
      wake_s2_r <= wake_s1_r;
      load_s1_r <= load_above_threshold;
      load_s2_r <= load_s1_r;
    end
  end

  wire sel_rise = sel_s2_r & ~sel_d_r;
  wire sel_fall = ~sel_s2_r & sel_d_r;
  // Serial clock is idle here, so link counters are stable
  wire frame_clocked = fall_seen_r;
  wire count_ok = (fall_cnt_r == 4'h0);
  wire accept = sel_rise & frame_clocked & count_ok;
  wire reject = sel_rise & frame_clocked & ~count_ok;

  // ----------------------------------------
  // Frame control, core domain
  // ----------------------------------------
  logic err_r;
  logic [15:0] word_r;
  logic [15:0] diag_r;

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      link_rst_r <= 1'b1;
      err_r <= 1'b0;
      word_r <= scp_pkg::WORD_RST;
      diag_r <= scp_pkg::WORD_RST;
    end else begin
      // Link domain leaves reset only once select has settled low
      if (sel_rise) begin
        link_rst_r <= 1'b1;
      end else if (sel_fall) begin
        link_rst_r <= 1'b0;
      end
      if (reject) begin
        err_r <= 1'b1;
      end else if (accept) begin
        err_r <= 1'b0;
      end
      if (accept) begin
        word_r <= in_shift_r;
      end
      // Snapshot frozen while the frame runs
      if (sel_s2_r) begin
        diag_r <= diag_word;
      end
    end
  end

  assign control_word = word_r;
  assign count_error = err_r;

  // ----------------------------------------
  // Word field decode
  // ----------------------------------------
  wire [2:0] new_mode_code = in_shift_r[scp_pkg::MODE_LSB +: scp_pkg::MODE_W];
  wire [1:0] new_cfg_sel = in_shift_r[scp_pkg::CFG_SEL_LSB +: scp_pkg::CFG_SEL_W];
  wire [8:0] new_cfg = in_shift_r[scp_pkg::CFG_LSB +: scp_pkg::CFG_W];
  wire new_meas = in_shift_r[scp_pkg::MEAS_BIT];
  wire new_wd_lp = in_shift_r[scp_pkg::WD_LP_BIT];

  logic mode_valid;
  scp_pkg::scp_mode_t mode_dec;

  always_comb begin
    mode_valid = 1'b1;
    mode_dec = scp_pkg::SCP_STANDBY;
    case (new_mode_code)
      scp_pkg::MODE_ACT_ON: mode_dec = scp_pkg::SCP_ACT_ON;
      scp_pkg::MODE_ACT_SLEEP: mode_dec = scp_pkg::SCP_ACT_SLEEP;
      scp_pkg::MODE_SLEEP: mode_dec = scp_pkg::SCP_SLEEP;
      scp_pkg::MODE_RX_ONLY: mode_dec = scp_pkg::SCP_RX_ONLY;
      scp_pkg::MODE_STOP: mode_dec = scp_pkg::SCP_STOP;
      default: mode_valid = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Mode register and watchdog latch
  // ----------------------------------------
  scp_pkg::scp_mode_t mode_r;
  logic meas_r;
  logic wd_lp_r;
  logic wd_keep_r;

  wire entering_stop = accept & mode_valid & (mode_dec == scp_pkg::SCP_STOP) & (mode_r != scp_pkg::SCP_STOP);

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mode_r <= scp_pkg::SCP_STANDBY;
      meas_r <= 1'b0;
      wd_lp_r <= 1'b0;
      wd_keep_r <= 1'b0;
    end else begin
      if (accept && mode_valid) begin
        mode_r <= mode_dec;
      end
      if (accept) begin
        meas_r <= new_meas;
        wd_lp_r <= new_wd_lp;
      end
      // Setting in force when stop is entered stays latched
      if (entering_stop) begin
        wd_keep_r <= wd_lp_r;
      end else if (accept && mode_valid && mode_dec != scp_pkg::SCP_STOP) begin
        wd_keep_r <= 1'b0;
      end
    end
  end

  wire is_active = (mode_r == scp_pkg::SCP_ACT_ON) | (mode_r == scp_pkg::SCP_ACT_SLEEP) |
                   (mode_r == scp_pkg::SCP_RX_ONLY);
  wire is_lowpow = (mode_r == scp_pkg::SCP_STOP) | (mode_r == scp_pkg::SCP_SLEEP);
  // Keep latch lets the watchdog ignore the load threshold
  wire wd_lowpow = (mode_r == scp_pkg::SCP_STOP) ?
                   (wd_lp_r & (wd_keep_r | load_s2_r)) :
                   wd_lp_r;

  // ----------------------------------------
  // Control outputs
  // ----------------------------------------
  assign mode = mode_r;
  assign ctrl = '{
    transceiver_on: (mode_r == scp_pkg::SCP_ACT_ON),
    transceiver_rx_only: (mode_r == scp_pkg::SCP_RX_ONLY),
    regulator_off: (mode_r == scp_pkg::SCP_SLEEP),
    meas_on: meas_r & is_active,
    watchdog_run: is_active | (is_lowpow & wd_lowpow),
    active: is_active
  };

  // ----------------------------------------
  // Configuration banks
  // ----------------------------------------
  logic [8:0] cfg_bank_r [scp_pkg::CFG_BANKS];

  for (genvar b = 0; b < scp_pkg::CFG_BANKS; b++) begin : g_bank
    always_ff @(posedge ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
        cfg_bank_r[b] <= scp_pkg::CFG_RST;
      end else if (accept && new_cfg_sel == 2'(b)) begin
        cfg_bank_r[b] <= new_cfg;
      end
    end
  end

  // One bank per selector value, in selector order
  assign cfg = '{
    general: cfg_bank_r[0],
    switches: cfg_bank_r[1],
    cyclic_wake: cfg_bank_r[2],
    watchdog: cfg_bank_r[3]
  };

  // ----------------------------------------
  // Wake hold in stop mode
  // ----------------------------------------
  // Cleared only by an accepted frame
  logic wake_hold_r;

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      wake_hold_r <= 1'b0;
    end else if (wake_s2_r && mode_r == scp_pkg::SCP_STOP) begin
      wake_hold_r <= 1'b1;
    end else if (accept) begin
      wake_hold_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Serial output
  // ----------------------------------------
  // Error level stands until the first rising edge
  wire err_phase = err_r & ~rise_seen_r;
  wire diag_bit = diag_r[out_idx_r];
  wire frame_bit = err_phase ? (1'b1 | serial_in) : diag_bit;

  // Wake hold overrides frame data
  assign serial_out = wake_hold_r ? 1'b0 : frame_bit;
  assign serial_out_oe = ~select_n | wake_hold_r;

endmodule : scp_serial_port
`default_nettype wire

// ===== testbench/scp_serial_port_checker.sv
// Concurrent checks on the serial control port outputs
`default_nettype none
module scp_serial_port_checker (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic select_n,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire scp_pkg::scp_mode_t mode,
  input wire scp_pkg::scp_ctrl_t ctrl,
  input wire logic [15:0] control_word,
  input wire logic count_error
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  chk_oe_in_frame: assert property (!select_n |-> serial_out_oe) else $error("oe low in frame");
  chk_oe_released: assert property (select_n && mode != scp_pkg::SCP_STOP &&
    $past(mode) != scp_pkg::SCP_STOP |-> !serial_out_oe) else $error("oe high outside frame");
  chk_word_steady: assert property (!select_n && $past(!select_n) |-> $stable(control_word))
    else $error("word moved in frame");
  chk_mode_commit: assert property ($changed(mode) |-> select_n && $past(select_n, 2))
    else $error("mode moved in frame");
  chk_err_flag: assert property (count_error && $fell(select_n) |-> serial_out) else $error("no error level");
  chk_meas_gate: assert property (ctrl.meas_on |-> ctrl.active) else $error("meas outside active");
  chk_wd_active: assert property (ctrl.active |-> ctrl.watchdog_run) else $error("watchdog off in active");
  chk_sleep_off: assert property (mode == scp_pkg::SCP_SLEEP |-> ctrl.regulator_off &&
    !ctrl.transceiver_on && !ctrl.active) else $error("sleep decode");
  chk_rx_only: assert property (mode == scp_pkg::SCP_RX_ONLY |-> ctrl.transceiver_rx_only)
    else $error("rx only decode");
  chk_act_on: assert property (mode == scp_pkg::SCP_ACT_ON |-> ctrl.transceiver_on && ctrl.active)
    else $error("active decode");
  chk_wake_low: assert property (select_n && serial_out_oe |-> !serial_out)
    else $error("wake hold not low");
endmodule : scp_serial_port_checker
bind scp_serial_port scp_serial_port_checker scp_serial_port_checker_inst (.ref_clk(ref_clk), .rstn(rstn),
  .select_n(select_n), .serial_out(serial_out), .serial_out_oe(serial_out_oe), .mode(mode), .ctrl(ctrl),
  .control_word(control_word), .count_error(count_error));
`default_nettype wire

// ===== testbench/scp_host_model.sv
// Host serial channel model: frames with a stopped clock between them
`default_nettype none
module scp_host_model (
  output var logic serial_clk,
  output var logic select_n,
  output var logic serial_in,
  input wire logic serial_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    serial_clk = 1'b0;
    select_n = 1'b1;
    serial_in = 1'b0;
  end
  task automatic frame(input logic [15:0] w, input int n, output logic [15:0] rx);
    select_n = 1'b0;
    #60;
    for (int i = 0; i < n; i++) begin
      if (i < 16) rx[i] = serial_out;
      serial_clk = 1'b1;
      #10 serial_in = w[i % 16];
      #52.5 serial_clk = 1'b0;
      #62.5;
    end
    select_n = 1'b1;
    serial_in = ~serial_in;
    #100;
  endtask : frame
endmodule : scp_host_model
`default_nettype wire

// ===== testbench/scp_serial_port_bench.sv
// Testbench of the serial control port
`default_nettype none
module scp_serial_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, rstn, serial_clk, select_n, serial_in, serial_out, serial_out_oe, count_error;
  logic wake_event = 1'b0;
  logic load_above_threshold = 1'b0;
  logic [15:0] diag_word, control_word, rx;
  scp_pkg::scp_mode_t mode;
  scp_pkg::scp_ctrl_t ctrl;
  scp_pkg::scp_cfg_t cfg;
  // Released line shows the inverse so a missing drive is caught
  wire logic line_seen = serial_out_oe ? serial_out : ~serial_out;
  logic [2:0] codes [5] = '{3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
  scp_pkg::scp_mode_t modes [5] = '{scp_pkg::SCP_ACT_SLEEP, scp_pkg::SCP_ACT_ON, scp_pkg::SCP_SLEEP,
    scp_pkg::SCP_RX_ONLY, scp_pkg::SCP_STOP};
  logic [5:0] ctrls [5] = '{6'h03, 6'h23, 6'h08, 6'h13, 6'h00};
  logic [2:0] rsv [3] = '{3'h0, 3'h1, 3'h5};
  int errors = 0;
  int tests_run = 0;
  scp_serial_port scp_serial_port_inst (.ref_clk(ref_clk), .rstn(rstn), .serial_clk(serial_clk),
    .select_n(select_n), .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .diag_word(diag_word), .wake_event(wake_event), .load_above_threshold(load_above_threshold),
    .mode(mode), .ctrl(ctrl), .cfg(cfg), .control_word(control_word), .count_error(count_error));
  scp_host_model scp_host_model_inst (.serial_clk(serial_clk), .select_n(select_n), .serial_in(serial_in),
    .serial_out(line_seen));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic check(input string name, input logic [35:0] exp, input logic [35:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  task automatic send(input logic [15:0] w, input int n);
    scp_host_model_inst.frame(w, n, rx);
    repeat (10) @(posedge ref_clk);
  endtask : send
  initial begin
    #200000;
    errors++;
    end_sim();
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    rstn = 1'b0;
    diag_word = 16'h0000;
    repeat (8) @(posedge ref_clk);
    #1 rstn = 1'b1;
    repeat (6) @(posedge ref_clk);
    check("mode", scp_pkg::SCP_STANDBY, mode);
    check("word", scp_pkg::WORD_RST, control_word);
    check("cfg", {4{scp_pkg::CFG_RST}}, cfg);
    #1 diag_word = 16'ha5c2;
    for (int i = 0; i < 5; i++) begin
      send({7'h00, 4'h0, 2'h0, codes[i]}, 16);
      check("mode", modes[i], mode);
      check("diag", 16'ha5c2, rx);
      check("ctrl", ctrls[i], ctrl);
      check("oe", 1'b0, serial_out_oe);
    end
    check("wd stop", 1'b0, ctrl.watchdog_run);
    $display("test modes done");
    for (int i = 0; i < 3; i++) begin
      send({2'h1, 9'h0a0 + 9'(i), 2'h0, rsv[i]}, 16);
      check("mode", scp_pkg::SCP_STOP, mode);
      check("general", 9'h0a0 + 9'(i), cfg.general);
      check("meas", 1'b0, ctrl.meas_on);
    end
    send({2'h1, 9'h000, 2'h0, 3'h4}, 16);
    check("wd sleep", 1'b0, ctrl.watchdog_run);
    check("reg off", 1'b1, ctrl.regulator_off);
    $display("test reserved done");
    for (int s = 0; s < 4; s++) begin
      send({2'h3, 9'h100 + 9'(s * 17), 2'(s), 3'h3}, 16);
      check("meas", 1'b1, ctrl.meas_on);
      check("wd act", 1'b1, ctrl.watchdog_run);
    end
    for (int s = 0; s < 4; s++) check("bank", 9'h100 + 9'(s * 17), 36'(cfg) >> ((3 - s) * 9) & 36'h1ff);
    $display("test banks done");
    send(16'h0004, 15);
    check("err", 1'b1, count_error);
    check("mode", scp_pkg::SCP_ACT_ON, mode);
    check("word", {2'h3, 9'h133, 2'h3, 3'h3}, control_word);
    send(16'h0002, 16);
    check("err bit", 1'b1, rx[0]);
    check("diag", 15'h52e1, rx[15:1]);
    check("err", 1'b0, count_error);
    check("mode", scp_pkg::SCP_ACT_SLEEP, mode);
    send(16'h0003, 32);
    check("mode", scp_pkg::SCP_ACT_ON, mode);
    check("word", 16'h0003, control_word);
    $display("test count done");
    send(16'h0007, 16);
    send(16'h8000, 16);
    check("wd late", 1'b0, ctrl.watchdog_run);
    #1 load_above_threshold = 1'b1;
    repeat (4) @(posedge ref_clk);
    check("wd load", 1'b1, ctrl.watchdog_run);
    #1 load_above_threshold = 1'b0;
    send(16'h8003, 16);
    send(16'h8007, 16);
    check("wd kept", 1'b1, ctrl.watchdog_run);
    $display("test watchdog done");
    #1 wake_event = 1'b1;
    repeat (5) @(posedge ref_clk);
    check("wake oe", 1'b1, serial_out_oe);
    check("wake out", 1'b0, serial_out);
    #1 wake_event = 1'b0;
    send(16'h0003, 16);
    check("wake rx", 16'h0000, rx);
    check("oe", 1'b0, serial_out_oe);
    check("mode", scp_pkg::SCP_ACT_ON, mode);
    $display("test wake done");
    end_sim();
  end
endmodule : scp_serial_port_bench
`default_nettype wire
